// file: hw/acsh_cfg.svh
// Purpose: Constants for the accumulator shuffle and table move datapath.
// Assumes: Included by bare name from every file that needs a figure.
// Notes:   Definitions only; no logic lives here.
`ifndef ACSH_CFG_SVH
`define ACSH_CFG_SVH

// Operation codes presented on the command port.
`define ACSH_OP_SHUFFLE 2'h0
`define ACSH_OP_MOVE 2'h1
`define ACSH_OP_COPY 2'h2

// Largest word count a table move accepts.
`define ACSH_MOVE_MAX_CNT 32'h0000_0040

// Digit geometry of the shuffle.
`define ACSH_NUM_DIGITS 8
`define ACSH_DIGIT_BITS 4

// Default sizes.
`define ACSH_ADDR_BITS 16
`define ACSH_DATA_BITS 16
`define ACSH_FIFO_DEPTH 8

// Read space select values.
`define ACSH_SPACE_WORD 1'b0
`define ACSH_SPACE_PROG 1'b1

`endif

// file: hw/acsh_pkg.sv
// Purpose: Shared types of the accumulator shuffle and table move datapath.
// Assumes: Nothing is imported; users write acsh_pkg::name.
// Notes:   Numbers live in acsh_cfg.svh, types live here.
`default_nettype none
package acsh_pkg;

  // One-hot sequencer states.
  typedef enum logic [2:0] {
    ACSH_ST_IDLE = 3'b001,
    ACSH_ST_XFER = 3'b010,
    ACSH_ST_DONE = 3'b100
  } acsh_state_type;

endpackage
`default_nettype wire

// file: hw/acsh_fifo.sv
// Purpose: Word FIFO between the memory read side and the write side.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Read data leave from a register; total occupancy never exceeds DEPTH.
`default_nettype none
module acsh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] mem_cnt_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  wire logic push_w;
  wire logic load_w;
  wire logic [CW:0] total_w;

  // Occupancy counts the output register too, so full is honest.
  assign total_w = {1'b0, mem_cnt_r} + {{CW{1'b0}}, out_valid_r};
  assign o_in_ready = total_w < (CW+1)'(DEPTH);
  assign push_w = i_in_valid && o_in_ready;
  assign load_w = (mem_cnt_r != '0) && (!out_valid_r || i_out_ready);
  assign o_out_valid = out_valid_r;
  assign o_out_data = out_data_r;

  // Storage array; written only on a push, never reset.
  always_ff @(posedge i_sys_clk) begin
    if (push_w) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // Pointers, count and the registered output stage.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      mem_cnt_r <= '0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (load_w) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        out_data_r <= mem_r[rd_ptr_r];
      end
      mem_cnt_r <= mem_cnt_r + CW'(push_w) - CW'(load_w);
      if (load_w) begin
        out_valid_r <= 1'b1;
      end else if (i_out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end
endmodule // acsh_fifo
`default_nettype wire

// file: hw/acsh_datapath.sv
// Purpose: Executes digit shuffle, table move and label-to-word-memory copy.
// Assumes: Operands are presented with a valid/ready handshake; memories answer reads later.
// Notes:   One read is outstanding at a time; words pass through a FIFO to the write port.
`include "acsh_cfg.svh"
`default_nettype none
module acsh_datapath #(
  parameter int AW = `ACSH_ADDR_BITS,
  parameter int DW = `ACSH_DATA_BITS,
  parameter int FIFO_DEPTH = `ACSH_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_op_valid,
  output logic o_op_ready,
  input wire logic [1:0] i_op_code,
  input wire logic [31:0] i_acc,
  input wire logic [31:0] i_stk1,
  input wire logic [31:0] i_stk2,
  input wire logic [AW-1:0] i_operand,
  output logic [31:0] o_acc_result,
  output logic o_done,
  output logic o_range_flag,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic o_rd_space,
  output logic [AW-1:0] o_rd_addr,
  input wire logic i_rd_data_valid,
  input wire logic [DW-1:0] i_rd_data,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [AW-1:0] o_wr_addr,
  output logic [DW-1:0] o_wr_data
);
  localparam int ND = `ACSH_NUM_DIGITS;
  localparam int DB = `ACSH_DIGIT_BITS;

  default clocking acsh_cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  acsh_pkg::acsh_state_type state_r;
  acsh_pkg::acsh_state_type state_nxt;
  logic [AW-1:0] rd_addr_r;
  logic [AW-1:0] wr_addr_r;
  logic [31:0] cnt_r;
  logic [31:0] rd_cnt_r;
  logic [31:0] wr_cnt_r;
  logic rd_pend_r;
  logic space_r;
  logic [31:0] acc_result_r;
  logic range_r;

  wire logic accept_w;
  wire logic is_shuf_w;
  wire logic is_move_w;
  wire logic is_copy_w;
  wire logic move_bad_w;
  wire logic [AW-1:0] copy_src_w;
  wire logic [AW-1:0] copy_dst_w;
  wire logic [31:0] shuf_word_w;
  wire logic rd_take_w;
  wire logic wr_take_w;
  wire logic xfer_end_w;
  wire logic fifo_in_ready_w;
  wire logic fifo_in_valid_w;

  // Command decode.
  assign accept_w = i_op_valid && o_op_ready;
  assign is_shuf_w = i_op_code == `ACSH_OP_SHUFFLE;
  assign is_move_w = i_op_code == `ACSH_OP_MOVE;
  assign is_copy_w = i_op_code == `ACSH_OP_COPY;
  // A count above the limit, or a source the address space cannot reach, is refused.
  assign move_bad_w = (i_stk1 > `ACSH_MOVE_MAX_CNT) || ((i_acc >> AW) != 32'h0000_0000);
  // The same offset moves both the label source and the destination block.
  assign copy_src_w = i_acc[AW-1:0] + i_stk1[AW-1:0];
  assign copy_dst_w = i_operand + i_stk1[AW-1:0];

  // Per result position, scan source positions upward so the higher duplicate overwrites.
  genvar gj;
  generate
    for (gj = 0; gj < ND; gj++) begin : g_dig
      logic [DB-1:0] dig_v;
      always_comb begin
        dig_v = '0;
        for (int i = 0; i < ND; i++) begin
          if (i_acc[DB*i +: DB] == DB'(gj + 1)) begin
            dig_v = i_stk1[DB*i +: DB];
          end
        end
      end
      assign shuf_word_w[DB*gj +: DB] = dig_v;
    end
  endgenerate

  // Transfer handshakes; a read is issued only when the FIFO can surely take its answer.
  assign o_rd_valid = (state_r == acsh_pkg::ACSH_ST_XFER) && !rd_pend_r && (rd_cnt_r != cnt_r) && fifo_in_ready_w;
  assign rd_take_w = o_rd_valid && i_rd_ready;
  assign fifo_in_valid_w = i_rd_data_valid && rd_pend_r;
  assign wr_take_w = o_wr_valid && i_wr_ready;
  assign xfer_end_w = wr_cnt_r == cnt_r;
  assign o_rd_addr = rd_addr_r;
  assign o_rd_space = space_r;
  assign o_wr_addr = wr_addr_r;
  assign o_op_ready = state_r == acsh_pkg::ACSH_ST_IDLE;
  assign o_done = state_r == acsh_pkg::ACSH_ST_DONE;
  assign o_acc_result = acc_result_r;
  assign o_range_flag = range_r;

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acsh_pkg::ACSH_ST_IDLE: begin
        if (accept_w) begin
          if ((is_move_w && !move_bad_w) || is_copy_w) begin
            state_nxt = acsh_pkg::ACSH_ST_XFER;
          end else begin
            state_nxt = acsh_pkg::ACSH_ST_DONE;
          end
        end
      end
      acsh_pkg::ACSH_ST_XFER: begin
        if (xfer_end_w) begin
          state_nxt = acsh_pkg::ACSH_ST_DONE;
        end
      end
      acsh_pkg::ACSH_ST_DONE: begin
        state_nxt = acsh_pkg::ACSH_ST_IDLE;
      end
      default: begin
        state_nxt = acsh_pkg::ACSH_ST_IDLE;
      end
    endcase
  end

  // Operand capture on acceptance.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= acsh_pkg::ACSH_ST_IDLE;
      acc_result_r <= 32'h0000_0000;
      range_r <= 1'b0;
      space_r <= `ACSH_SPACE_WORD;
      cnt_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (accept_w) begin
        range_r <= is_move_w && move_bad_w;
        if (is_shuf_w) begin
          acc_result_r <= shuf_word_w;
        end
        space_r <= is_copy_w ? `ACSH_SPACE_PROG : `ACSH_SPACE_WORD;
        cnt_r <= is_copy_w ? i_stk2 : i_stk1;
      end
    end
  end

  // Address and progress counters of a transfer.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_addr_r <= '0;
      wr_addr_r <= '0;
      rd_cnt_r <= 32'h0000_0000;
      wr_cnt_r <= 32'h0000_0000;
      rd_pend_r <= 1'b0;
    end else if (accept_w) begin
      rd_addr_r <= is_copy_w ? copy_src_w : i_acc[AW-1:0];
      wr_addr_r <= is_copy_w ? copy_dst_w : i_operand;
      rd_cnt_r <= 32'h0000_0000;
      wr_cnt_r <= 32'h0000_0000;
      rd_pend_r <= 1'b0;
    end else begin
      if (rd_take_w) begin
        rd_addr_r <= rd_addr_r + 1'b1;
        rd_cnt_r <= rd_cnt_r + 32'h0000_0001;
        rd_pend_r <= 1'b1;
      end else if (fifo_in_valid_w) begin
        rd_pend_r <= 1'b0;
      end
      if (wr_take_w) begin
        wr_addr_r <= wr_addr_r + 1'b1;
        wr_cnt_r <= wr_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Read answers queue here so a slow write side stalls further reads.
  acsh_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_in_valid(fifo_in_valid_w),
    .o_in_ready(fifo_in_ready_w),
    .i_in_data(i_rd_data),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(o_wr_data)
  );

  // Checks of the operation results and sequencing.
  a_shuf_done_next: assert property (accept_w && is_shuf_w |=> o_done ##1 o_op_ready)
    else $error("shuffle did not finish in one cycle");
  a_shuf_identity_order: assert property (accept_w && is_shuf_w && i_acc == 32'h8765_4321
    |=> o_acc_result == $past(i_stk1))
    else $error("identity order changed the digits");
  a_shuf_invalid_zero: assert property (accept_w && is_shuf_w && i_acc == 32'hf900_0000
    |=> o_acc_result == 32'h0000_0000)
    else $error("invalid order digits did not clear the result");
  a_shuf_dup_msd: assert property (accept_w && is_shuf_w && i_acc == 32'h1111_1111
    |=> o_acc_result == {28'h000_0000, $past(i_stk1[31:28])})
    else $error("duplicate order digit did not take the most significant");
  a_move_range_flag: assert property (accept_w && is_move_w && i_stk1 > 32'h0000_0040
    |=> o_range_flag && o_done ##1 !o_rd_valid && o_range_flag)
    else $error("oversized move was not refused with the flag");
  a_move_src_start: assert property (accept_w && is_move_w && !move_bad_w
    |=> o_rd_addr == $past(i_acc[AW-1:0]) && o_rd_space == `ACSH_SPACE_WORD)
    else $error("move source address wrong");
  a_move_dst_start: assert property (accept_w && is_move_w && !move_bad_w
    |=> o_wr_addr == $past(i_operand) && !o_range_flag)
    else $error("move destination address wrong");
  a_copy_offsets: assert property (accept_w && is_copy_w
    |=> o_rd_addr == $past(copy_src_w) && o_wr_addr == $past(copy_dst_w) && o_rd_space)
    else $error("copy offset not applied to both ends");
  a_count_bound: assert property (o_rd_valid |-> rd_cnt_r < cnt_r && wr_cnt_r <= rd_cnt_r)
    else $error("read issued beyond the word count");
  a_write_order: assert property (wr_take_w |=> o_wr_addr == $past(wr_addr_r) + 1'b1)
    else $error("destination did not advance by one word");
endmodule // acsh_datapath
`default_nettype wire

// file: bench/accumulator_shuffle_and_table_move_tb.sv
// Purpose: Self-checking bench for the shuffle and table move datapath.
// Assumes: Reads are answered one cycle after acceptance; writes are logged by a monitor.
// Notes:   Idle read data flips every cycle so a stale word can never pass for a fresh one.
`include "acsh_cfg.svh"
`default_nettype none
module accumulator_shuffle_and_table_move_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic [31:0] acc = 32'h0;
  logic [31:0] stk1 = 32'h0;
  logic [31:0] stk2 = 32'h0;
  logic [15:0] operand = 16'h0;
  logic [31:0] acc_result;
  logic done, range_flag, op_ready, rd_valid, rd_space, wr_valid;
  logic rd_ready = 1'b1;
  logic wr_ready = 1'b1;
  logic rd_dv = 1'b0;
  logic tk = 1'b0;
  logic ps = 1'b0;
  logic [15:0] rd_data = 16'h0;
  logic [15:0] pa = 16'h0;
  logic [15:0] rd_addr, wr_addr, wr_data;
  logic [15:0] wa_q[$];
  logic [15:0] wd_q[$];
  int rdn = 0;
  int miscompares = 0;
  int n_compared = 0;
  int lat;

  // Free-running system clock.
  always #5 clk = ~clk;

  acsh_datapath i_acsh_datapath (.i_sys_clk(clk), .i_arst_n(arst_n), .i_op_valid(op_valid),
    .o_op_ready(op_ready), .i_op_code(op_code), .i_acc(acc), .i_stk1(stk1), .i_stk2(stk2),
    .i_operand(operand), .o_acc_result(acc_result), .o_done(done), .o_range_flag(range_flag),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_space(rd_space), .o_rd_addr(rd_addr),
    .i_rd_data_valid(rd_dv), .i_rd_data(rd_data), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data));

  function automatic logic [15:0] pat(input logic [15:0] a, input logic s);
    return a ^ {s, 15'h2a5a};
  endfunction

  // Later source digits overwrite earlier ones, so the most significant duplicate wins.
  function automatic logic [31:0] shuf(input logic [31:0] d, input logic [31:0] o);
    logic [31:0] r;
    logic [3:0] p;
    r = 32'h0;
    for (int i = 0; i < 8; i++) begin
      p = o[i*4+:4];
      if (p >= 4'h1 && p <= 4'h8) r[(p-1)*4+:4] = d[i*4+:4];
    end
    return r;
  endfunction

  // Log accepted reads and every write taken by the memory side.
  always @(posedge clk) begin
    tk <= rd_valid && rd_ready;
    if (rd_valid && rd_ready) begin
      pa <= rd_addr;
      ps <= rd_space;
      rdn <= rdn + 1;
    end
    if (wr_valid && wr_ready) begin
      wa_q.push_back(wr_addr);
      wd_q.push_back(wr_data);
    end
  end

  // Read answer pulses for one cycle; between answers the data bus keeps changing.
  always @(negedge clk) begin
    rd_dv <= tk;
    rd_data <= tk ? pat(pa, ps) : ~rd_data;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Issues one command and waits for done; lat is the count of cycles after the first.
  task automatic cmd(input logic [1:0] c, input logic [31:0] a, input logic [31:0] s1,
                     input logic [31:0] s2, input logic [15:0] d);
    wa_q.delete();
    wd_q.delete();
    rdn = 0;
    @(negedge clk);
    op_valid = 1'b1;
    op_code = c;
    acc = a;
    stk1 = s1;
    stk2 = s2;
    operand = d;
    @(negedge clk);
    op_valid = 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 2000) begin
      @(negedge clk);
      lat++;
    end
    chk("done_seen", 32'h1, {31'h0, done});
  endtask

  task automatic xfer(input int n, input logic [15:0] src, input logic [15:0] dst, input logic sp);
    logic [15:0] ea;
    chk("wr_count", n, wa_q.size());
    foreach (wa_q[k]) begin
      ea = dst + 16'(k);
      chk("wr_addr", {16'h0, ea}, {16'h0, wa_q[k]});
      chk("wr_data", {16'h0, pat(src + 16'(k), sp)}, {16'h0, wd_q[k]});
    end
  endtask

  task automatic t_shuffle();
    logic [31:0] dv[6] = '{32'h8765_4321, 32'h8765_4321, 32'h8765_4321,
                           32'h1357_9bdf, 32'hfedc_ba98, 32'h8765_4321};
    logic [31:0] ov[6] = '{32'h1234_5678, 32'h9a0f_1243, 32'h1111_2233,
                           32'h8765_4321, 32'hf900_0000, 32'h1111_1111};
    for (int i = 0; i < 6; i++) begin
      cmd(`ACSH_OP_SHUFFLE, ov[i], dv[i], 32'h0, 16'h0);
      chk("shuf_lat", 32'h0, lat);
      chk("shuf_res", shuf(dv[i], ov[i]), acc_result);
    end
    $display("shuffle test done");
  endtask

  // Largest count with the write side stalled, so the buffer fills and reads must stop.
  task automatic t_move_full();
    fork
      cmd(`ACSH_OP_MOVE, 32'h0000_0400, `ACSH_MOVE_MAX_CNT, 32'h0, 16'h0418);
      begin
        wr_ready = 1'b0;
        repeat (40) @(negedge clk);
        chk("fill_reads", `ACSH_FIFO_DEPTH, rdn);
        wr_ready = 1'b1;
      end
    join
    xfer(64, 16'h0400, 16'h0418, `ACSH_SPACE_WORD);
    chk("flag_ok", 32'h0, {31'h0, range_flag});
    $display("move test done");
  endtask

  task automatic t_move_reject();
    cmd(`ACSH_OP_MOVE, 32'h0000_0400, 32'h0000_0041, 32'h0, 16'h0418);
    chk("rej_lat", 32'h0, lat);
    chk("rej_cnt_flag", 32'h1, {31'h0, range_flag});
    chk("rej_cnt_wr", 32'h0, wa_q.size());
    // An unused code finishes at once and clears the flag left by the refusal.
    cmd(2'h3, 32'h0, 32'h0, 32'h0, 16'h0);
    chk("noop_lat", 32'h0, lat);
    chk("noop_flag", 32'h0, {31'h0, range_flag});
    cmd(`ACSH_OP_MOVE, 32'h0001_0000, 32'h0000_0002, 32'h0, 16'h0418);
    chk("rej_src_flag", 32'h1, {31'h0, range_flag});
    chk("rej_src_wr", 32'h0, wa_q.size());
    $display("reject test done");
  endtask

  // Reset in mid-run, with a result and a raised flag standing, must clear both.
  task automatic t_reset();
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    chk("rst_result", 32'h0, acc_result);
    chk("rst_outs", 32'h8, {28'h0, op_ready, done, range_flag, rd_valid | wr_valid});
    @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("rst_ready", 32'h1, {31'h0, op_ready});
    $display("reset test done");
  endtask

  // Copy with the read side stalled at first; offset moves both source and destination.
  task automatic t_copy();
    fork
      cmd(`ACSH_OP_COPY, 32'h0000_0100, 32'h0000_0003, 32'h0000_0004, 16'h0500);
      begin
        rd_ready = 1'b0;
        repeat (6) @(negedge clk);
        rd_ready = 1'b1;
      end
    join
    xfer(4, 16'h0103, 16'h0503, `ACSH_SPACE_PROG);
    chk("copy_flag", 32'h0, {31'h0, range_flag});
    // A zero count ends two cycles after acceptance with nothing written.
    cmd(`ACSH_OP_COPY, 32'h0000_0100, 32'h0, 32'h0, 16'h0500);
    chk("copy0_lat", 32'h1, lat);
    chk("copy0_wr", 32'h0, wa_q.size());
    $display("copy test done");
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole run takes a few hundred cycles; the limit leaves ample margin.
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    t_shuffle();
    t_move_full();
    t_move_reject();
    t_reset();
    t_copy();
    end_of_test();
  end
endmodule // accumulator_shuffle_and_table_move_tb
`default_nettype wire
